/* pkg/alert_accum_defines.svh */
// Purpose: named offsets, reset values and widths of the alert mask and accumulator bank
// Assumes: eight-bit register port, byte offsets as printed
// Notes: definitions only
`ifndef ALERT_ACCUM_DEFINES_SVH
`define ALERT_ACCUM_DEFINES_SVH

// =====================================================================
// register offsets
`define ADDR_CHARGE_MASK 8'h8b
`define ADDR_ENERGY_MASK 8'h8c
`define ADDR_OVERFLOW_MASK 8'h8d
`define ADDR_TIMEBASE_MASK 8'h8e
`define ADDR_SUPPLY_MASK 8'h8f
`define ADDR_OCC_ONE_CTRL 8'hde
`define ADDR_OCC_TWO_CTRL 8'hdf
`define ADDR_ACC_CTRL_ONE 8'he1
`define ADDR_ACC_CTRL_TWO 8'he2
`define ADDR_DEADBAND_ONE 8'he4
`define ADDR_DEADBAND_TWO 8'he5

// =====================================================================
// implemented bits of each mask register and of accumulator control one
`define CHARGE_MASK_USED 8'h3f
`define ENERGY_MASK_USED 8'hcf
`define OVERFLOW_MASK_USED 8'hb7
`define TIMEBASE_MASK_USED 8'hff
`define SUPPLY_MASK_USED 8'h03
`define ACC_CTRL_ONE_USED 8'h0f

// =====================================================================
// reset values
`define MASK_RESET 8'hff
`define CTRL_RESET 8'h00
`define DEADBAND_RESET 8'h00
`define READ_IDLE 8'h00

// =====================================================================
// alert bit positions and data widths
`define SUPPLY_OCC_ONE_BIT 2
`define SUPPLY_OCC_TWO_BIT 3
`define REG_W 8
`define CUR_W 24
`define ACC_W 48
`define GAIN_W 8
`define ACC_COUNT 6

`endif

/* pkg/alert_accum_pkg.sv */
// Purpose: types shared by the alert mask and accumulator bank
// Assumes: widths from alert_accum_defines.svh
// Notes: field order of the control structs follows the bit layout, msb first
`include "alert_accum_defines.svh"

package alert_accum_pkg;

    // =================================================================
    // accumulation gate encoding
    typedef enum logic [1:0] {
        ACC_ALWAYS,
        ACC_POSITIVE,
        ACC_NEGATIVE,
        ACC_NEVER
    } accum_mode_e;

    typedef struct packed {
        logic [1:0] overcurrent_polarity;
        logic [1:0] overcurrent_deglitch;
        logic [2:0] overcurrent_threshold;
        logic overcurrent_enable;
    } occ_control_s;

    typedef struct packed {
        logic [3:0] unused;
        accum_mode_e second_current_gate;
        accum_mode_e first_current_gate;
    } acc_control_one_s;

    typedef struct packed {
        accum_mode_e weighted_energy_second_gate;
        accum_mode_e weighted_energy_first_gate;
        accum_mode_e weighted_charge_second_gate;
        accum_mode_e weighted_charge_first_gate;
    } acc_control_two_s;

    typedef struct packed {
        logic [`REG_W-1:0] charge_alert_flags;
        logic [`REG_W-1:0] energy_alert_flags;
        logic [`REG_W-1:0] overflow_alert_flags;
        logic [`REG_W-1:0] timebase_alert_flags;
        logic [`REG_W-1:0] supply_alert_flags;
    } alert_flags_s;

    typedef struct packed {
        logic signed [`CUR_W-1:0] current_one;
        logic signed [`CUR_W-1:0] current_two;
        logic signed [`CUR_W-1:0] power_one;
        logic signed [`CUR_W-1:0] power_two;
    } sample_s;

    typedef struct packed {
        logic signed [`ACC_W-1:0] charge_one;
        logic signed [`ACC_W-1:0] charge_two;
        logic signed [`ACC_W-1:0] charge_weighted;
        logic signed [`ACC_W-1:0] energy_one;
        logic signed [`ACC_W-1:0] energy_two;
        logic signed [`ACC_W-1:0] energy_weighted;
    } accum_s;

endpackage : alert_accum_pkg

/* logic/alert_mask_accum_control.sv */
// Purpose: alert masks steering heartbeat stop, overcurrent and accumulator control
// Assumes: register port and all inputs except sys_rst_i synchronous to mclk_i
// Notes: accumulators and threshold triggers update one cycle after a sample
`include "alert_accum_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module alert_mask_accum_control (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [`REG_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [`REG_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [`REG_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire alert_accum_pkg::alert_flags_s alert_flags_i,
    input wire logic heartbeat_a_config_i,
    input wire logic sample_valid_i,
    input wire alert_accum_pkg::sample_s sample_i,
    input wire logic [`GAIN_W-1:0] gain_one_i,
    input wire logic [`GAIN_W-1:0] gain_two_i,
    output logic heartbeat_a_stop_o,
    output logic heartbeat_b_enable_o,
    output logic heartbeat_b_stop_o,
    output alert_accum_pkg::occ_control_s overcurrent_one_cfg_o,
    output alert_accum_pkg::occ_control_s overcurrent_two_cfg_o,
    output alert_accum_pkg::accum_s accum_o,
    output logic [`ACC_COUNT-1:0] threshold_check_o
);

    // =================================================================
    // register state
    logic [`REG_W-1:0] charge_alert_mask_reg, charge_alert_mask_next;
    logic [`REG_W-1:0] energy_alert_mask_reg, energy_alert_mask_next;
    logic [`REG_W-1:0] overflow_alert_mask_reg, overflow_alert_mask_next;
    logic [`REG_W-1:0] timebase_alert_mask_reg, timebase_alert_mask_next;
    logic [`REG_W-1:0] supply_alert_mask_reg, supply_alert_mask_next;
    alert_accum_pkg::occ_control_s occ_one_reg, occ_one_next;
    alert_accum_pkg::occ_control_s occ_two_reg, occ_two_next;
    alert_accum_pkg::acc_control_one_s acc_ctrl_one_reg, acc_ctrl_one_next;
    alert_accum_pkg::acc_control_two_s acc_ctrl_two_reg, acc_ctrl_two_next;
    logic [`REG_W-1:0] deadband_one_reg, deadband_one_next;
    logic [`REG_W-1:0] deadband_two_reg, deadband_two_next;
    logic [`REG_W-1:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    always_comb begin
        charge_alert_mask_next = charge_alert_mask_reg;
        energy_alert_mask_next = energy_alert_mask_reg;
        overflow_alert_mask_next = overflow_alert_mask_reg;
        timebase_alert_mask_next = timebase_alert_mask_reg;
        supply_alert_mask_next = supply_alert_mask_reg;
        occ_one_next = occ_one_reg;
        occ_two_next = occ_two_reg;
        acc_ctrl_one_next = acc_ctrl_one_reg;
        acc_ctrl_two_next = acc_ctrl_two_reg;
        deadband_one_next = deadband_one_reg;
        deadband_two_next = deadband_two_reg;
        if (reg_wr_i) begin
            // unimplemented mask bits are dropped so they read back zero
            unique case (reg_addr_i)
                `ADDR_CHARGE_MASK: charge_alert_mask_next = reg_wdata_i & `CHARGE_MASK_USED;
                `ADDR_ENERGY_MASK: energy_alert_mask_next = reg_wdata_i & `ENERGY_MASK_USED;
                `ADDR_OVERFLOW_MASK: overflow_alert_mask_next = reg_wdata_i & `OVERFLOW_MASK_USED;
                `ADDR_TIMEBASE_MASK: timebase_alert_mask_next = reg_wdata_i & `TIMEBASE_MASK_USED;
                `ADDR_SUPPLY_MASK: supply_alert_mask_next = reg_wdata_i & `SUPPLY_MASK_USED;
                `ADDR_OCC_ONE_CTRL: occ_one_next = reg_wdata_i;
                `ADDR_OCC_TWO_CTRL: occ_two_next = reg_wdata_i;
                `ADDR_ACC_CTRL_ONE: acc_ctrl_one_next = reg_wdata_i & `ACC_CTRL_ONE_USED;
                `ADDR_ACC_CTRL_TWO: acc_ctrl_two_next = reg_wdata_i;
                `ADDR_DEADBAND_ONE: deadband_one_next = reg_wdata_i;
                `ADDR_DEADBAND_TWO: deadband_two_next = reg_wdata_i;
                default: ;
            endcase
        end
        rvalid_next = reg_rd_i;
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `ADDR_CHARGE_MASK: rdata_next = charge_alert_mask_reg;
                `ADDR_ENERGY_MASK: rdata_next = energy_alert_mask_reg;
                `ADDR_OVERFLOW_MASK: rdata_next = overflow_alert_mask_reg;
                `ADDR_TIMEBASE_MASK: rdata_next = timebase_alert_mask_reg;
                `ADDR_SUPPLY_MASK: rdata_next = supply_alert_mask_reg;
                `ADDR_OCC_ONE_CTRL: rdata_next = occ_one_reg;
                `ADDR_OCC_TWO_CTRL: rdata_next = occ_two_reg;
                `ADDR_ACC_CTRL_ONE: rdata_next = acc_ctrl_one_reg;
                `ADDR_ACC_CTRL_TWO: rdata_next = acc_ctrl_two_reg;
                `ADDR_DEADBAND_ONE: rdata_next = deadband_one_reg;
                `ADDR_DEADBAND_TWO: rdata_next = deadband_two_reg;
                default: rdata_next = `READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            charge_alert_mask_reg <= `MASK_RESET & `CHARGE_MASK_USED;
            energy_alert_mask_reg <= `MASK_RESET & `ENERGY_MASK_USED;
            overflow_alert_mask_reg <= `MASK_RESET & `OVERFLOW_MASK_USED;
            timebase_alert_mask_reg <= `MASK_RESET & `TIMEBASE_MASK_USED;
            supply_alert_mask_reg <= `MASK_RESET & `SUPPLY_MASK_USED;
            occ_one_reg <= `CTRL_RESET;
            occ_two_reg <= `CTRL_RESET;
            acc_ctrl_one_reg <= `CTRL_RESET;
            acc_ctrl_two_reg <= `CTRL_RESET;
            deadband_one_reg <= `DEADBAND_RESET;
            deadband_two_reg <= `DEADBAND_RESET;
            rdata_reg <= `READ_IDLE;
            rvalid_reg <= 1'b0;
        end else begin
            charge_alert_mask_reg <= charge_alert_mask_next;
            energy_alert_mask_reg <= energy_alert_mask_next;
            overflow_alert_mask_reg <= overflow_alert_mask_next;
            timebase_alert_mask_reg <= timebase_alert_mask_next;
            supply_alert_mask_reg <= supply_alert_mask_next;
            occ_one_reg <= occ_one_next;
            occ_two_reg <= occ_two_next;
            acc_ctrl_one_reg <= acc_ctrl_one_next;
            acc_ctrl_two_reg <= acc_ctrl_two_next;
            deadband_one_reg <= deadband_one_next;
            deadband_two_reg <= deadband_two_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // =================================================================
    // heartbeat control
    logic hb_a_stop_reg, hb_a_stop_next;
    logic hb_b_enable_reg, hb_b_enable_next;
    logic hb_b_stop_reg, hb_b_stop_next;
    logic masked_alert;
    logic occ_alert;

    always_comb begin
        // a one in the mask hides the alert, but supply bits 2 and 3 still stop heartbeat a through occ_alert
        masked_alert = |(alert_flags_i.charge_alert_flags & ~charge_alert_mask_reg
                         & `CHARGE_MASK_USED)
            | |(alert_flags_i.energy_alert_flags & ~energy_alert_mask_reg & `ENERGY_MASK_USED)
            | |(alert_flags_i.overflow_alert_flags & ~overflow_alert_mask_reg
                & `OVERFLOW_MASK_USED)
            | |(alert_flags_i.timebase_alert_flags & ~timebase_alert_mask_reg
                & `TIMEBASE_MASK_USED)
            | |(alert_flags_i.supply_alert_flags & ~supply_alert_mask_reg & `SUPPLY_MASK_USED);
        occ_alert = alert_flags_i.supply_alert_flags[`SUPPLY_OCC_ONE_BIT]
            | alert_flags_i.supply_alert_flags[`SUPPLY_OCC_TWO_BIT];
        hb_a_stop_next = heartbeat_a_config_i & (masked_alert | occ_alert);
        hb_b_enable_next = occ_one_reg.overcurrent_enable | occ_two_reg.overcurrent_enable;
        hb_b_stop_next = hb_b_enable_next & occ_alert;
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hb_a_stop_reg <= 1'b0;
            hb_b_enable_reg <= 1'b0;
            hb_b_stop_reg <= 1'b0;
        end else begin
            hb_a_stop_reg <= hb_a_stop_next;
            hb_b_enable_reg <= hb_b_enable_next;
            hb_b_stop_reg <= hb_b_stop_next;
        end
    end

    // =================================================================
    // accumulation gating
    // sign gate shared by every field
    function automatic logic gate_ok(input alert_accum_pkg::accum_mode_e mode,
                                     input logic signed [`CUR_W-1:0] cur);
        logic ok;
        ok = 1'b0;
        unique case (mode)
            alert_accum_pkg::ACC_ALWAYS: ok = 1'b1;
            alert_accum_pkg::ACC_POSITIVE: ok = (cur > 0);
            alert_accum_pkg::ACC_NEGATIVE: ok = (cur < 0);
            alert_accum_pkg::ACC_NEVER: ok = 1'b0;
        endcase
        return ok;
    endfunction : gate_ok

    // magnitude of most-negative input comes out exact when read unsigned, still far above any deadband
    function automatic logic [`CUR_W-1:0] magnitude(input logic signed [`CUR_W-1:0] cur);
        logic [`CUR_W-1:0] mag;
        mag = cur[`CUR_W-1] ? `CUR_W'(-cur) : `CUR_W'(cur);
        return mag;
    endfunction : magnitude

    alert_accum_pkg::accum_s acc_reg, acc_next;
    logic [`ACC_COUNT-1:0] check_reg, check_next;
    logic db_one_ok, db_two_ok;
    logic g_c1, g_c2, g_e1, g_e2, g_wc1, g_wc2, g_we1, g_we2;
    logic signed [`CUR_W+`GAIN_W:0] w_cur_one, w_cur_two, w_pow_one, w_pow_two;

    always_comb begin
        db_one_ok = magnitude(sample_i.current_one) >= `CUR_W'(deadband_one_reg);
        db_two_ok = magnitude(sample_i.current_two) >= `CUR_W'(deadband_two_reg);
        g_c1 = db_one_ok & gate_ok(acc_ctrl_one_reg.first_current_gate, sample_i.current_one);
        g_e1 = g_c1;
        g_c2 = db_two_ok & gate_ok(acc_ctrl_one_reg.second_current_gate, sample_i.current_two);
        g_e2 = g_c2;
        g_wc1 = db_one_ok
            & gate_ok(acc_ctrl_two_reg.weighted_charge_first_gate, sample_i.current_one);
        g_wc2 = db_two_ok
            & gate_ok(acc_ctrl_two_reg.weighted_charge_second_gate, sample_i.current_two);
        g_we1 = db_one_ok
            & gate_ok(acc_ctrl_two_reg.weighted_energy_first_gate, sample_i.current_one);
        g_we2 = db_two_ok
            & gate_ok(acc_ctrl_two_reg.weighted_energy_second_gate, sample_i.current_two);
        w_cur_one = sample_i.current_one * $signed({1'b0, gain_one_i});
        w_cur_two = sample_i.current_two * $signed({1'b0, gain_two_i});
        w_pow_one = sample_i.power_one * $signed({1'b0, gain_one_i});
        w_pow_two = sample_i.power_two * $signed({1'b0, gain_two_i});

        acc_next = acc_reg;
        check_next = '0;
        if (sample_valid_i) begin
            // each accumulator takes its own quantity
            if (g_c1) begin
                acc_next.charge_one = acc_reg.charge_one + `ACC_W'(sample_i.current_one);
            end
            if (g_c2) begin
                acc_next.charge_two = acc_reg.charge_two + `ACC_W'(sample_i.current_two);
            end
            if (g_e1) begin
                acc_next.energy_one = acc_reg.energy_one + `ACC_W'(sample_i.power_one);
            end
            if (g_e2) begin
                acc_next.energy_two = acc_reg.energy_two + `ACC_W'(sample_i.power_two);
            end
            acc_next.charge_weighted = acc_reg.charge_weighted
                + (g_wc1 ? `ACC_W'(w_cur_one) : `ACC_W'(0))
                + (g_wc2 ? `ACC_W'(w_cur_two) : `ACC_W'(0));
            acc_next.energy_weighted = acc_reg.energy_weighted
                + (g_we1 ? `ACC_W'(w_pow_one) : `ACC_W'(0))
                + (g_we2 ? `ACC_W'(w_pow_two) : `ACC_W'(0));
            check_next = {g_we1 | g_we2, g_e2, g_e1, g_wc1 | g_wc2, g_c2, g_c1};
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_reg <= '0;
            check_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            check_reg <= check_next;
        end
    end

    // =================================================================
    // outputs
    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;
    assign heartbeat_a_stop_o = hb_a_stop_reg;
    assign heartbeat_b_enable_o = hb_b_enable_reg;
    assign heartbeat_b_stop_o = hb_b_stop_reg;
    assign overcurrent_one_cfg_o = occ_one_reg;
    assign overcurrent_two_cfg_o = occ_two_reg;
    assign accum_o = acc_reg;
    assign threshold_check_o = check_reg;

endmodule : alert_mask_accum_control

`default_nettype wire

/* tb/alert_mask_accum_control_chk.sv */
// Purpose: port assertions for alert_mask_accum_control
// Assumes: one clock domain, asynchronous active high reset
// Notes: heartbeat and config outputs lag their cause by one edge
`include "alert_accum_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module alert_mask_accum_control_chk (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [`REG_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [`REG_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    input wire alert_accum_pkg::alert_flags_s alert_flags_i,
    input wire logic heartbeat_a_config_i,
    input wire logic sample_valid_i,
    input wire logic heartbeat_a_stop_o,
    input wire logic heartbeat_b_enable_o,
    input wire logic heartbeat_b_stop_o,
    input wire alert_accum_pkg::occ_control_s overcurrent_one_cfg_o,
    input wire alert_accum_pkg::occ_control_s overcurrent_two_cfg_o,
    input wire alert_accum_pkg::accum_s accum_o,
    input wire logic [`ACC_COUNT-1:0] threshold_check_o
);
    logic occ_hit;
    logic any_en;
    assign occ_hit = alert_flags_i.supply_alert_flags[2] | alert_flags_i.supply_alert_flags[3];
    assign any_en = overcurrent_one_cfg_o.overcurrent_enable | overcurrent_two_cfg_o.overcurrent_enable;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // ======
    // heartbeat control
    AST_OCC_UNMASKED: assert property (heartbeat_a_config_i && occ_hit |=> heartbeat_a_stop_o)
        else $error("overcurrent flag did not stop heartbeat a");
    AST_A_UNCONFIG: assert property (!heartbeat_a_config_i |=> !heartbeat_a_stop_o)
        else $error("heartbeat a stopped while not configured");
    AST_B_ENABLE: assert property (heartbeat_b_enable_o == $past(any_en))
        else $error("heartbeat b enable does not follow comparator enables");
    AST_B_STOP_ON: assert property ((any_en && occ_hit) ##1 (any_en && occ_hit) |=> heartbeat_b_stop_o)
        else $error("heartbeat b not stopped by enabled overcurrent");
    AST_B_STOP_OFF: assert property (!any_en ##1 !any_en |=> !heartbeat_b_stop_o)
        else $error("heartbeat b stopped with comparators disabled");
    // ======
    // register port
    AST_RVALID: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read valid not one cycle after read strobe");
    AST_OCC1_WRITE: assert property (reg_wr_i && reg_addr_i == `ADDR_OCC_ONE_CTRL
        |=> overcurrent_one_cfg_o == $past(reg_wdata_i))
        else $error("comparator one control not written");
    AST_OCC2_HOLD: assert property (!(reg_wr_i && reg_addr_i == `ADDR_OCC_TWO_CTRL)
        |=> $stable(overcurrent_two_cfg_o))
        else $error("comparator two control changed without a write");
    // ======
    // accumulation
    AST_CHECK_AFTER_SAMPLE: assert property (|threshold_check_o |-> $past(sample_valid_i))
        else $error("threshold check without a preceding sample");
    AST_ACC_HOLD: assert property (!sample_valid_i |=> $stable(accum_o))
        else $error("accumulator moved without a sample");
endmodule : alert_mask_accum_control_chk
`default_nettype wire

/* tb/alert_mask_accum_control_tb.sv */
// Purpose: self-checking bench for alert_mask_accum_control
// Assumes: checker bound below, inputs driven on falling edges
// Notes: drivers queue expectations, one monitor pops and compares
`timescale 1ns/1ns
`default_nettype none
module alert_mask_accum_control_tb;
    logic mclk_i = 1'b0, sys_rst_i = 1'b1, wr = 1'b0, rd = 1'b0, cfg_a = 1'b0, sv = 1'b0;
    logic hb_probe = 1'b0, rvalid, hb_a, hb_b_en, hb_b;
    logic [7:0] addr = 8'h00, wdata = 8'h00, g1 = 8'h00, g2 = 8'h00, rdata, ctl1, ctl2;
    logic [7:0] db1 = 8'h00, db2 = 8'h00;
    alert_accum_pkg::alert_flags_s flags = '0;
    alert_accum_pkg::sample_s smp = '0;
    alert_accum_pkg::accum_s acc;
    alert_accum_pkg::occ_control_s occ1, occ2;
    logic [5:0] chk;
    logic [7:0] rd_q[$];
    logic [2:0] hb_q[$];
    logic [293:0] acc_q[$];
    logic signed [47:0] m[6] = '{default: '0};
    logic [7:0] ra[11] = '{8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'hde, 8'hdf, 8'he1, 8'he2, 8'he4, 8'he5};
    logic [7:0] rv[11] = '{8'h3f, 8'hcf, 8'hb7, 8'hff, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] um[11] = '{8'h3f, 8'hcf, 8'hb7, 8'hff, 8'h03, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
    int fails = 0, samples_checked = 0;
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    alert_mask_accum_control alert_mask_accum_control_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .alert_flags_i(flags), .heartbeat_a_config_i(cfg_a),
        .sample_valid_i(sv), .sample_i(smp), .gain_one_i(g1), .gain_two_i(g2),
        .heartbeat_a_stop_o(hb_a), .heartbeat_b_enable_o(hb_b_en), .heartbeat_b_stop_o(hb_b),
        .overcurrent_one_cfg_o(occ1), .overcurrent_two_cfg_o(occ2), .accum_o(acc),
        .threshold_check_o(chk));
    // ======
    // drivers and compares
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge mclk_i);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_i);
        rd_q.push_back(e);
        addr = a;
        rd = 1'b1;
        @(negedge mclk_i);
        rd = 1'b0;
    endtask : rd_reg
    // spare cycles only: pin b stop registers on the same edge as its enable
    task automatic probe(input logic [2:0] e);
        repeat (2) @(negedge mclk_i);
        hb_q.push_back(e);
        hb_probe = 1'b1;
        @(negedge mclk_i);
        hb_probe = 1'b0;
    endtask : probe
    function automatic logic gate(input logic [1:0] md, input logic signed [23:0] c);
        return md == 2'd0 || (md == 2'd1 && c > 0) || (md == 2'd2 && c < 0);
    endfunction : gate
    task automatic sample(input logic [7:0] ga, input logic [7:0] gb);
        logic signed [23:0] c1, c2, p1, p2;
        logic d1, d2, k1, k2, w1, w2, e1, e2;
        c1 = $urandom_range(1) ? 24'($urandom_range(600)) - 24'd300 : {16'h0, db1} - 24'($urandom_range(1));
        c2 = $urandom_range(1) ? 24'($urandom_range(600)) - 24'd300 : {16'h0, db2} - 24'($urandom_range(1));
        p1 = 24'($urandom);
        p2 = 24'($urandom);
        d1 = (c1 < 0 ? -c1 : c1) >= {16'h0, db1};
        d2 = (c2 < 0 ? -c2 : c2) >= {16'h0, db2};
        k1 = gate(ctl1[1:0], c1) && d1;
        k2 = gate(ctl1[3:2], c2) && d2;
        w1 = gate(ctl2[1:0], c1) && d1;
        w2 = gate(ctl2[3:2], c2) && d2;
        e1 = gate(ctl2[5:4], c1) && d1;
        e2 = gate(ctl2[7:6], c2) && d2;
        m[0] += k1 ? c1 : 48'sd0;
        m[1] += k2 ? c2 : 48'sd0;
        m[2] += (w1 ? c1 * $signed({1'b0, ga}) : 48'sd0) + (w2 ? c2 * $signed({1'b0, gb}) : 48'sd0);
        m[3] += k1 ? p1 : 48'sd0;
        m[4] += k2 ? p2 : 48'sd0;
        m[5] += (e1 ? p1 * $signed({1'b0, ga}) : 48'sd0) + (e2 ? p2 * $signed({1'b0, gb}) : 48'sd0);
        @(negedge mclk_i);
        if ({e1 | e2, k2, k1, w1 | w2, k2, k1} != 6'h00) begin
            acc_q.push_back({e1 | e2, k2, k1, w1 | w2, k2, k1, m[0], m[1], m[2], m[3], m[4], m[5]});
        end
        smp = {c1, c2, p1, p2};
        g1 = ga;
        g2 = gb;
        sv = 1'b1;
    endtask : sample
    task automatic cmp8(input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (e !== s) begin
            fails++;
            $display("unexpected read data expected %h seen %h", e, s);
        end
    endtask : cmp8
    task automatic cmp_hb(input logic [2:0] e, input logic [2:0] s);
        samples_checked++;
        if (e !== s) begin
            fails++;
            $display("unexpected heartbeat outputs expected %h seen %h", e, s);
        end
    endtask : cmp_hb
    task automatic cmp_acc(input logic [293:0] e, input logic [293:0] s);
        samples_checked++;
        if (e !== s) begin
            fails++;
            $display("unexpected accumulators expected %h seen %h", e, s);
        end
    endtask : cmp_acc
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // ======
    // monitor
    initial begin
        forever begin
            @(posedge mclk_i);
            #1;
            if (rvalid === 1'b1) cmp8(rd_q.pop_front(), rdata);
            if (chk !== 6'h00) cmp_acc(acc_q.pop_front(), {chk, acc});
            if (hb_probe === 1'b1) cmp_hb(hb_q.pop_front(), {hb_a, hb_b_en, hb_b});
        end
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        fails++;
        stop_test();
    end
    // ======
    // scenarios
    initial begin
        void'($urandom(66894));
        repeat (3) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'b0;
        foreach (ra[i]) rd_reg(ra[i], rv[i]);
        wr_reg(8'h90, 8'hff);
        rd_reg(8'h90, 8'h00);
        foreach (ra[i]) wr_reg(ra[i], 8'hff);
        foreach (ra[i]) rd_reg(ra[i], um[i]);
        for (int i = 5; i < 11; i++) wr_reg(ra[i], 8'h00);
        for (int r = 0; r < 5; r++) begin
            for (int b = 0; b < 8; b++) begin
                wr_reg(ra[r], ~(8'h01 << b));
                cfg_a = 1'($urandom);
                flags = '0;
                flags[8 * (4 - r) + b] = 1'b1;
                probe({cfg_a & (um[r][b] | (r == 4 && (b == 2 || b == 3))), 2'b00});
            end
        end
        wr_reg(8'h8f, 8'hff);
        cfg_a = 1'b1;
        for (int k = 0; k < 16; k++) begin
            wr_reg(8'hde, {7'($urandom), k[0]});
            wr_reg(8'hdf, {7'($urandom), k[1]});
            flags = {32'h0, 4'h0, k[3:2], 2'b11};
            probe({|k[3:2], |k[1:0], |k[3:2] & |k[1:0]});
        end
        wr_reg(8'hde, 8'h00);
        wr_reg(8'hdf, 8'h00);
        for (int i = 0; i < 40; i++) begin
            ctl1 = i < 4 ? {4'h0, i[1:0], i[1:0]} : 8'($urandom);
            ctl2 = i < 4 ? {4{i[1:0]}} : 8'($urandom);
            db1 = 8'($urandom_range(200));
            db2 = 8'($urandom_range(200));
            wr_reg(8'he1, ctl1);
            wr_reg(8'he2, ctl2);
            wr_reg(8'he4, db1);
            wr_reg(8'he5, db2);
            repeat (2) sample(8'($urandom), 8'($urandom));
            @(negedge mclk_i);
            sv = 1'b0;
        end
        for (int t = 0; t < 20 && rd_q.size() + hb_q.size() + acc_q.size() > 0; t++) @(negedge mclk_i);
        if (rd_q.size() + hb_q.size() + acc_q.size() > 0) fails++;
        stop_test();
    end
endmodule : alert_mask_accum_control_tb
bind alert_mask_accum_control alert_mask_accum_control_chk chk_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o), .alert_flags_i(alert_flags_i),
    .heartbeat_a_config_i(heartbeat_a_config_i), .sample_valid_i(sample_valid_i),
    .heartbeat_a_stop_o(heartbeat_a_stop_o), .heartbeat_b_enable_o(heartbeat_b_enable_o),
    .heartbeat_b_stop_o(heartbeat_b_stop_o), .overcurrent_one_cfg_o(overcurrent_one_cfg_o),
    .overcurrent_two_cfg_o(overcurrent_two_cfg_o), .accum_o(accum_o),
    .threshold_check_o(threshold_check_o));
`default_nettype wire
